//--- rtl/gpcp_counter.sv
`timescale 1ns/1ps
`default_nettype none
`include "gpcp_defs.svh"
module gpcp_counter
	import gpcp_pkg::*;
#(
	parameter int W = 24
) (
	input wire logic pclk,
	input wire logic presetn,
	gpcp_ctr_if.cnt  bus
);
	////////////////////////////////////////////////////////////////////
	logic [W-1:0]   count;     // Counter contents
	gpcp_state_type state;     // Idle or armed
	logic           src_q;     // Previous source level
	logic           gate_sy;   // Gate delayed for synchronized gating
	logic           gate_prev; // Previous effective gate
	logic           raw_out;   // Output before polarity

	wire gpcp_dir_type dir  = gpcp_dir_type'(bus.mode[`GPCP_M_DIR]);
	wire [1:0]         om   = bus.mode[`GPCP_M_OMODE];
	// Active source edge, rising or falling
	wire src_edge = bus.mode[`GPCP_M_SPOL] ? (src_q & ~bus.src)
		: (~src_q & bus.src);
	// Synchronized gating trades one cycle of latency for clean edges
	wire gate_lvl = (bus.mode[`GPCP_M_GSYNC] ? gate_sy : bus.gate)
		^ bus.mode[`GPCP_M_GPOL];
	wire gate_rise = gate_lvl & ~gate_prev;
	// Direction: pin low counts down, high counts up
	wire up = (dir == GPCP_UP) | ((dir == GPCP_PIN) & bus.up_pin)
		| ((dir == GPCP_GATE) & gate_lvl);
	// One step per active edge, paused while gate inactive
	wire step = (state == GPCP_ARMED) & src_edge
		& (~bus.mode[`GPCP_M_GATING] | gate_lvl);
	// Plain wrap at both ends, with only a flag out
	wire at_end = up ? (&count) : (count == '0);
	wire [W-1:0] next_count = up ? W'(count + 1'b1) : W'(count - 1'b1);
	wire tc_now = step & at_end;
	wire gev_now = (state == GPCP_ARMED) & gate_rise;
	wire toggle = (om == `GPCP_OM_TOG_TC & tc_now)
		| (om == `GPCP_OM_TOG_ANY & (tc_now | gev_now));
	wire next_raw = (om == `GPCP_OM_PULSE) ? tc_now : raw_out ^ toggle;

	////////////////////////////////////////////////////////////////////
	// Input history
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_q     <= 1'b0;
			gate_sy   <= 1'b0;
			gate_prev <= 1'b0;
		end else begin
			src_q     <= bus.src;
			gate_sy   <= bus.gate;
			gate_prev <= gate_lvl;
		end
	end

	// Arm starts the programmed operation, reset stops it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= GPCP_IDLE;
		end else if (bus.clr) begin
			state <= GPCP_IDLE;
		end else if (bus.arm) begin
			state <= GPCP_ARMED;
		end
	end

	// Count register; reset beats load, load beats a step
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= '0;
		end else if (bus.clr) begin
			count <= '0;
		end else if (bus.load) begin
			count <= bus.load_val;
		end else if (step) begin
			count <= next_count;
		end
	end

	// Hardware capture on gate, software capture on command
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus.hw_save <= '0;
			bus.sw_save <= '0;
		end else begin
			if (gev_now) begin
				bus.hw_save <= count;
			end
			// Snapshot only; counting goes on
			if (bus.save) begin
				bus.sw_save <= count;
			end
		end
	end

	// Event pulses and output waveform
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus.tc       <= 1'b0;
			bus.gate_evt <= 1'b0;
			raw_out      <= 1'b0;
			bus.out_lvl  <= 1'b0;
		end else begin
			bus.tc       <= tc_now;
			bus.gate_evt <= gev_now;
			raw_out      <= bus.clr ? 1'b0 : next_raw;
			bus.out_lvl  <= (bus.clr ? 1'b0 : next_raw)
				^ ~bus.mode[`GPCP_M_OPOL];
		end
	end

	assign bus.armed = (state == GPCP_ARMED);
endmodule : gpcp_counter
`default_nettype wire

//--- rtl/gpcp_ctr_if.sv
`timescale 1ns/1ps
`default_nettype none
interface gpcp_ctr_if #(parameter int W = 24);
	logic         arm;      // Arm pulse
	logic         clr;      // Counter reset pulse
	logic         save;     // Software save pulse
	logic         load;     // Load pulse
	logic [W-1:0] load_val; // Selected load register
	logic [23:0]  mode;     // Mode word
	logic         src;      // Source level
	logic         gate;     // Gate level
	logic         up_pin;   // Up/down pin level
	logic [W-1:0] hw_save;  // Gate-event capture
	logic [W-1:0] sw_save;  // Software capture
	logic         tc;       // Rollover pulse
	logic         gate_evt; // Active gate edge pulse
	logic         out_lvl;  // Counter output
	logic         armed;    // Counting allowed
	modport ctl (output arm, clr, save, load, load_val, mode, src, gate,
		up_pin, input hw_save, sw_save, tc, gate_evt, out_lvl, armed);
	modport cnt (input arm, clr, save, load, load_val, mode, src, gate,
		up_pin, output hw_save, sw_save, tc, gate_evt, out_lvl, armed);
endinterface : gpcp_ctr_if
`default_nettype wire

//--- rtl/gpcp_defs.svh
`ifndef GPCP_DEFS_SVH
`define GPCP_DEFS_SVH
// APB word addresses of the global registers
`define GPCP_A_CTRL     8'h00
`define GPCP_A_FOUT     8'h04
`define GPCP_A_IRQ_ST   8'h08
`define GPCP_A_IRQ_MASK 8'h0C
// Address group (paddr[7:5]) of the global window and of each counter window
`define GPCP_G_GLOBAL   3'h0
`define GPCP_G_CTR0     3'h1
`define GPCP_G_CTR1     3'h2
// Register slots (paddr[4:2]) inside a counter window
`define GPCP_R_CMD      3'h0
`define GPCP_R_MODE     3'h1
`define GPCP_R_LOAD_XA  3'h2
`define GPCP_R_LOAD_YB  3'h5
`define GPCP_R_HW_SAVE  3'h6
`define GPCP_R_SW_SAVE  3'h7
// Command bits (write) of the command slot; a read gives {gate_err, tc_err, armed}
`define GPCP_C_ARM      0
`define GPCP_C_RESET    1
`define GPCP_C_SAVE     2
`define GPCP_C_LOAD     3
`define GPCP_C_GACK     4
`define GPCP_C_TACK     5
`define GPCP_C_GERR     6
`define GPCP_C_TERR     7
// Mode register fields
`define GPCP_M_DIR      1:0
`define GPCP_M_GATING   2
`define GPCP_M_GPOL     3
`define GPCP_M_SPOL     4
`define GPCP_M_BANK     5
`define GPCP_M_LREG     6
`define GPCP_M_GSYNC    7
`define GPCP_M_TCIE     8
`define GPCP_M_GIE      9
`define GPCP_M_OMODE    11:10
`define GPCP_M_OPOL     12
`define GPCP_M_AUTO     23:16
`define GPCP_MODE_MASK  24'hFF1FFF
// Global control fields
`define GPCP_K_OEN      0
`define GPCP_K_OSEL     1
`define GPCP_K_TSEL     4:2
`define GPCP_K_C1SEL    5
// Frequency output fields; a zero factor means sixteen
`define GPCP_F_DIV      3:0
`define GPCP_F_TB       4
`define GPCP_F_EN       5
`define GPCP_F_ZERO_DIV 5'h10
// Output waveform modes
`define GPCP_OM_PULSE   2'h1
`define GPCP_OM_TOG_TC  2'h2
`define GPCP_OM_TOG_ANY 2'h3
`endif

//--- rtl/gpcp_pkg.sv
`default_nettype none
package gpcp_pkg;
	// Counter run state, Gray coded
	typedef enum logic {
		GPCP_IDLE  = 1'b0,
		GPCP_ARMED = 1'b1
	} gpcp_state_type;
	// Direction selector values
	typedef enum logic [1:0] {
		GPCP_DOWN = 2'h0,
		GPCP_UP   = 2'h1,
		GPCP_PIN  = 2'h2,
		GPCP_GATE = 2'h3
	} gpcp_dir_type;
endpackage : gpcp_pkg
`default_nettype wire

//--- rtl/gpcp_top.sv
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "gpcp_defs.svh"
module gpcp_top
	import gpcp_pkg::*;
#(
	parameter int W = 24
) (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [7:0] paddr,
	input  wire logic       psel,
	input  wire logic       penable,
	input  wire logic       pwrite,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic       pready,
	output var  logic       pslverr,
	output var  logic       irq,
	input  wire logic [1:0] source_in,
	input  wire logic [1:0] gate_in,
	input  wire logic [1:0] up_down_pin,
	input  wire logic       first_internal_timebase,
	input  wire logic       second_internal_timebase,
	input  wire logic [6:0] trigger_bus_line,
	input  wire logic       divide_counter_terminal_count,
	input  wire logic       counter_zero_out_or_trigger_io_in,
	output var  logic       counter_zero_out_or_trigger_io_out,
	output var  logic       counter_zero_out_or_trigger_io_oe,
	output var  logic       trigger_io_to_selectors,
	output var  logic       counter_one_out_or_divider_tc,
	output var  logic       freq_out
);
	////////////////////////////////////////////////////////////////////
	// Register state
	logic [5:0]   ctrl;          // Pin routing control
	logic [5:0]   fout;          // Frequency output control
	logic [3:0]   irq_st;        // Sticky events: {g1,t1,g0,t0}
	logic [3:0]   irq_mask;      // Interrupt mask, same layout
	logic [23:0]  mode [2];      // Per-counter mode word
	logic [W-1:0] load_mem [8];  // {counter, bank, A/B} load registers
	logic [1:0]   tc_err;        // Rollover while still pending
	logic [1:0]   gate_err;      // Gate event while still pending
	logic [1:0]   arm_p;         // Command pulses to the counters
	logic [1:0]   clr_p;
	logic [1:0]   save_p;
	logic [1:0]   load_p;
	logic         tb_q;          // Previous timebase level
	logic [4:0]   div_cnt;       // Timebase edges in this period

	// Counter results, one entry per counter
	logic [W-1:0] hw_save [2];
	logic [W-1:0] sw_save [2];
	logic [1:0]   tc_ev;
	logic [1:0]   gate_ev;
	logic [1:0]   ctr_out;
	logic [1:0]   armed;

	////////////////////////////////////////////////////////////////////
	// APB decode; the slave always answers in the first access cycle
	wire       wr_en   = psel & penable & pready & pwrite;
	wire       rd_done = psel & penable & pready & ~pwrite;
	wire [2:0] grp     = paddr[7:5];
	wire [2:0] ro      = paddr[4:2];
	wire       is_ctr  = (grp == `GPCP_G_CTR0) | (grp == `GPCP_G_CTR1);
	wire       ci      = (grp == `GPCP_G_CTR1);
	wire [2:0] lofs    = 3'(ro - `GPCP_R_LOAD_XA);
	wire       is_load = (ro >= `GPCP_R_LOAD_XA) & (ro <= `GPCP_R_LOAD_YB);
	wire [2:0] lidx    = {ci, lofs[1:0]};
	// Global window holds four words; misaligned access is refused
	wire mapped = (paddr[1:0] == 2'h0)
		& (is_ctr | ((grp == `GPCP_G_GLOBAL) & (ro <= 3'h3)));
	wire is_glob = mapped & ~is_ctr;
	wire wr_ok   = wr_en & mapped;

	// Global writes, status read and load register writes
	wire wr_ctrl = wr_ok & is_glob & (paddr == `GPCP_A_CTRL);
	wire wr_fout = wr_ok & is_glob & (paddr == `GPCP_A_FOUT);
	wire wr_mask = wr_ok & is_glob & (paddr == `GPCP_A_IRQ_MASK);
	wire rd_st   = rd_done & is_glob & (paddr == `GPCP_A_IRQ_ST);
	wire wr_load = wr_ok & is_ctr & is_load;

	////////////////////////////////////////////////////////////////////
	// Read data mux, taken in the setup cycle
	wire [W-1:0] ctr_word =
		(ro == `GPCP_R_HW_SAVE) ? hw_save[ci] :
		(ro == `GPCP_R_SW_SAVE) ? sw_save[ci] :
		is_load ? load_mem[lidx] :
		(ro == `GPCP_R_MODE) ? W'(mode[ci]) :
		W'({gate_err[ci], tc_err[ci], armed[ci]});
	wire [31:0] glob_word =
		(paddr == `GPCP_A_CTRL) ? {26'h0, ctrl} :
		(paddr == `GPCP_A_FOUT) ? {26'h0, fout} :
		(paddr == `GPCP_A_IRQ_ST) ? {28'h0, irq_st} :
		{28'h0, irq_mask};
	wire [31:0] next_rdata = !mapped ? 32'h0 :
		is_ctr ? 32'(ctr_word) : glob_word;

	// Handshake and read data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~mapped;
			prdata  <= (psel & ~penable) ? next_rdata : prdata;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Per-counter decode, flag update terms and the counters themselves
	logic [1:0] cmd_wr;   // Write to the command slot
	logic [1:0] mode_wr;  // Write to the mode slot
	logic [3:0] set_ev;   // Enabled events this cycle
	logic [3:0] ack_ev;   // Write-one acknowledges this cycle
	logic [1:0] next_tc_err;
	logic [1:0] next_gate_err;

	// Two identical counters with their own windows
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_ctr
			gpcp_ctr_if #(.W(W)) bus ();
			assign cmd_wr[gi]  = wr_ok & is_ctr & (ci == gi)
				& (ro == `GPCP_R_CMD);
			assign mode_wr[gi] = wr_ok & is_ctr & (ci == gi)
				& (ro == `GPCP_R_MODE);
			assign set_ev[2*gi]   = tc_ev[gi] & mode[gi][`GPCP_M_TCIE];
			assign set_ev[2*gi+1] = gate_ev[gi] & mode[gi][`GPCP_M_GIE];
			// Only a one acknowledges; a zero leaves the flag
			assign ack_ev[2*gi]   = cmd_wr[gi] & pwdata[`GPCP_C_TACK];
			assign ack_ev[2*gi+1] = cmd_wr[gi] & pwdata[`GPCP_C_GACK];
			// A fresh event while still pending is an error; set wins
			assign next_tc_err[gi] = (set_ev[2*gi] & irq_st[2*gi])
				| (tc_err[gi] & ~(cmd_wr[gi] & pwdata[`GPCP_C_TERR]));
			assign next_gate_err[gi] = (set_ev[2*gi+1] & irq_st[2*gi+1])
				| (gate_err[gi] & ~(cmd_wr[gi] & pwdata[`GPCP_C_GERR]));
			// Load from the selected bank and register
			assign bus.load_val = load_mem[{1'(gi),
				mode[gi][`GPCP_M_BANK], mode[gi][`GPCP_M_LREG]}];
			assign bus.arm    = arm_p[gi];
			assign bus.clr    = clr_p[gi];
			assign bus.save   = save_p[gi];
			assign bus.load   = load_p[gi];
			assign bus.mode   = mode[gi];
			assign bus.src    = source_in[gi];
			assign bus.gate   = gate_in[gi];
			assign bus.up_pin = up_down_pin[gi];
			assign hw_save[gi] = bus.hw_save;
			assign sw_save[gi] = bus.sw_save;
			assign tc_ev[gi]   = bus.tc;
			assign gate_ev[gi] = bus.gate_evt;
			assign ctr_out[gi] = bus.out_lvl;
			assign armed[gi]   = bus.armed;
			gpcp_counter #(.W(W)) u_ctr (
				.pclk    (pclk),
				.presetn (presetn),
				.bus     (bus.cnt)
			);
		end
	endgenerate

	// Status: events set, a status read or a write-one clears; set wins
	wire [3:0] next_irq_st = set_ev | (irq_st & ~ack_ev & {4{~rd_st}});

	////////////////////////////////////////////////////////////////////
	// Global control registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl     <= 6'h0;
			fout     <= 6'h0;
			irq_mask <= 4'h0;
		end else begin
			if (wr_ctrl) begin
				ctrl <= pwdata[5:0];
			end
			if (wr_fout) begin
				fout <= pwdata[5:0];
			end
			if (wr_mask) begin
				irq_mask <= pwdata[3:0];
			end
		end
	end

	// Sticky status, error flags and the interrupt line
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_st   <= 4'h0;
			tc_err   <= 2'h0;
			gate_err <= 2'h0;
			irq      <= 1'b0;
		end else begin
			irq_st   <= next_irq_st;
			tc_err   <= next_tc_err;
			gate_err <= next_gate_err;
			irq      <= |(next_irq_st & irq_mask);
		end
	end

	// Mode words; cleared by reset, written by software through the mode slot
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode[0] <= 24'h0;
			mode[1] <= 24'h0;
		end else begin
			if (mode_wr[0]) begin
				mode[0] <= pwdata[23:0] & `GPCP_MODE_MASK;
			end
			if (mode_wr[1]) begin
				mode[1] <= pwdata[23:0] & `GPCP_MODE_MASK;
			end
		end
	end

	// Load registers; no reset needed, software loads before use
	always_ff @(posedge pclk) begin
		if (wr_load) begin
			load_mem[lidx] <= pwdata[W-1:0];
		end
	end

	// Command pulses, one cycle each, a cycle after the write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			arm_p  <= 2'h0;
			clr_p  <= 2'h0;
			save_p <= 2'h0;
			load_p <= 2'h0;
		end else begin
			arm_p  <= cmd_wr & {2{pwdata[`GPCP_C_ARM]}};
			clr_p  <= cmd_wr & {2{pwdata[`GPCP_C_RESET]}};
			save_p <= cmd_wr & {2{pwdata[`GPCP_C_SAVE]}};
			load_p <= cmd_wr & {2{pwdata[`GPCP_C_LOAD]}};
		end
	end

	////////////////////////////////////////////////////////////////////
	// Frequency output divider
	wire       tb      = fout[`GPCP_F_TB] ? second_internal_timebase
		: first_internal_timebase;
	wire       tb_edge = tb & ~tb_q;
	wire [4:0] factor  = (fout[`GPCP_F_DIV] == 4'h0) ? `GPCP_F_ZERO_DIV
		: {1'b0, fout[`GPCP_F_DIV]};
	wire       div_wrap = (div_cnt >= 5'(factor - 5'h1));

	// Disabled divider sits at zero, so re-enabling starts a clean
	// period; changing factor while enabled may give one odd period
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tb_q     <= 1'b0;
			div_cnt  <= 5'h0;
			freq_out <= 1'b0;
		end else begin
			tb_q <= tb;
			if (!fout[`GPCP_F_EN]) begin
				div_cnt <= 5'h0;
			end else if (tb_edge) begin
				div_cnt <= div_wrap ? 5'h0 : 5'(div_cnt + 5'h1);
			end
			freq_out <= fout[`GPCP_F_EN] & tb_edge & div_wrap;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Pin routing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			counter_zero_out_or_trigger_io_out <= 1'b0;
			counter_zero_out_or_trigger_io_oe  <= 1'b0;
			trigger_io_to_selectors            <= 1'b0;
			counter_one_out_or_divider_tc      <= 1'b0;
		end else begin
			// Counter 0 or one trigger line when driving
			counter_zero_out_or_trigger_io_out <= ctrl[`GPCP_K_OSEL]
				? trigger_bus_line[ctrl[`GPCP_K_TSEL]] : ctr_out[0];
			counter_zero_out_or_trigger_io_oe  <= ctrl[`GPCP_K_OEN];
			// Incoming level to the selectors when not driving
			trigger_io_to_selectors <= ~ctrl[`GPCP_K_OEN]
				& counter_zero_out_or_trigger_io_in;
			// Counter 1 or divide-counter terminal count
			counter_one_out_or_divider_tc <= ctrl[`GPCP_K_C1SEL]
				? divide_counter_terminal_count : ctr_out[1];
		end
	end
endmodule : gpcp_top
`default_nettype wire

//--- testbench/gpcp_bench.sv
`timescale 1ns/1ps
`default_nettype none
module gpcp_bench;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic        rerr;                       // Error of last transfer
	logic [1:0]  source_in, gate_in, up_down_pin;
	logic        first_internal_timebase, second_internal_timebase;
	logic        divide_counter_terminal_count;
	logic [6:0]  trigger_bus_line;
	logic        counter_zero_out_or_trigger_io_in;
	logic        counter_zero_out_or_trigger_io_out;
	logic        counter_zero_out_or_trigger_io_oe;
	logic        trigger_io_to_selectors, counter_one_out_or_divider_tc;
	logic        freq_out;
	int          miscompares, compares, n, k, c;
	logic [4:0]  fset [4] = '{5'h01, 5'h13, 5'h00, 5'h1F}; // Timebase, div
	int          fper [4] = '{4, 18, 64, 90};  // Expected pulse spacing
	gpcp_top i_gpcp_top (.*);
	gpcp_far_model i_gpcp_far_model (.*);
	always #5 pclk = ~pclk;
	////////////////////////////////////////////////////////////////
	task automatic stop_test();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: %h vs %h", $time, seen, exp);
		end
	endtask : chk
	// One APB transfer; idle cycles after keep drivers apart
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int t;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		t = 0;
		do begin
			@(posedge pclk);
			t++;
		end while (pready !== 1'b1 && t < 16);
		if (pready !== 1'b1) begin
			miscompares++;
			stop_test();
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask : xfer
	// Counter cleanup: sync gate on, all pending flags acknowledged
	task automatic ctr_reset(input logic [7:0] b);
		xfer(1, b + 8'h04, 32'h80);
		xfer(1, b, 32'hF2);
		xfer(0, b, 0);
		chk(rdat, 0);
	endtask : ctr_reset
	task automatic ctr_start(input logic [7:0] b, input logic [31:0] m,
		input logic [31:0] v);
		ctr_reset(b);
		xfer(1, b + 8'h04, m);
		xfer(1, b + 8'h08, v);
		xfer(1, b, 32'h08);
		xfer(1, b, 32'h01);
		xfer(0, b, 0);
		chk(rdat, 1);
	endtask : ctr_start
	task automatic ctr_save(input logic [7:0] b, input logic [31:0] e);
		xfer(1, b, 32'h04);
		xfer(0, b + 8'h1C, 0);
		chk(rdat, e);
	endtask : ctr_save
	initial begin
		repeat (100000) @(posedge pclk);
		miscompares++;
		stop_test();
	end
	////////////////////////////////////////////////////////////////
	initial begin
		{pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{gate_in, up_down_pin, trigger_bus_line} = '0;
		divide_counter_terminal_count = 1'b0;
		counter_zero_out_or_trigger_io_in = 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		// Unmapped and misaligned places are refused
		xfer(0, 8'h10, 0);
		chk({rerr, rdat[30:0]}, 32'h80000000);
		xfer(0, 8'h01, 0);
		chk(rerr, 1);
		// Idle counter outputs with low polarity read high
		xfer(1, 8'h00, 32'h01);
		chk(counter_zero_out_or_trigger_io_oe, 1);
		chk(counter_zero_out_or_trigger_io_out, 1);
		chk(counter_one_out_or_divider_tc, 1);
		// Trigger line three driven onto the shared pin
		trigger_bus_line <= 7'h08;
		xfer(1, 8'h00, 32'h0F);
		chk(counter_zero_out_or_trigger_io_out, 1);
		trigger_bus_line <= 7'h77;
		repeat (3) @(posedge pclk);
		chk(counter_zero_out_or_trigger_io_out, 0);
		// Pin as input, pin one from the divider terminal count
		divide_counter_terminal_count <= 1'b1;
		counter_zero_out_or_trigger_io_in <= 1'b1;
		xfer(1, 8'h00, 32'h20);
		chk(counter_one_out_or_divider_tc, 1);
		chk(trigger_io_to_selectors, 1);
		divide_counter_terminal_count <= 1'b0;
		repeat (3) @(posedge pclk);
		chk(counter_one_out_or_divider_tc, 0);
		// Frequency output: disable, program, enable, then measure
		for (k = 0; k < 4; k++) begin
			xfer(1, 8'h04, 0);
			xfer(1, 8'h04, {27'h0, fset[k]});
			xfer(1, 8'h04, {27'h1, fset[k]});
			for (n = 0; n < 2; n++) begin
				c = 0;
				do begin
					@(posedge pclk);
					c++;
				end while (freq_out !== 1'b1 && c < 300);
			end
			chk(c, fper[k]);
		end
		xfer(1, 8'h04, 0);
		// Load registers of both counters kept apart
		for (k = 0; k < 8; k++)
			xfer(1, 8'h28 + 8'h20 * k[2] + 8'h04 * k[1:0], 32'hA5C30000 + k);
		for (k = 0; k < 8; k++) begin
			xfer(0, 8'h28 + 8'h20 * k[2] + 8'h04 * k[1:0], 0);
			chk(rdat, 32'h00C30000 + k);
		end
		xfer(1, 8'h24, 32'hFFFFFFFF);
		xfer(0, 8'h24, 0);
		chk(rdat, 32'h00FF1FFF);
		// Up count across the top, save while counting
		xfer(1, 8'h0C, 32'h01);
		ctr_start(8'h20, 32'h181, 32'hFFFFFE);
		i_gpcp_far_model.pulse(0, 1, 3);
		ctr_save(8'h20, 32'hFFFFFF);
		chk(irq, 0);
		i_gpcp_far_model.pulse(0, 2, 9);
		ctr_save(8'h20, 32'h1);
		i_gpcp_far_model.pulse(0, 1, 3);
		ctr_save(8'h20, 32'h2);
		chk(irq, 1);
		xfer(1, 8'h20, 0);
		repeat (3) @(posedge pclk);
		chk(irq, 1);
		xfer(1, 8'h20, 32'h20);
		repeat (3) @(posedge pclk);
		chk(irq, 0);
		// Down count under zero, status cleared by reading
		ctr_start(8'h20, 32'h1980, 0);
		chk(counter_zero_out_or_trigger_io_out, 0);
		i_gpcp_far_model.pulse(0, 1, 3);
		ctr_save(8'h20, 32'hFFFFFF);
		chk(counter_zero_out_or_trigger_io_out, 1);
		xfer(0, 8'h08, 0);
		chk(rdat, 1);
		xfer(0, 8'h08, 0);
		chk(rdat, 0);
		chk(irq, 0);
		// Direction from the dedicated pin on counter one
		ctr_start(8'h40, 32'h82, 32'h5);
		i_gpcp_far_model.pulse(1, 2, 3);
		ctr_save(8'h40, 32'h3);
		up_down_pin <= 2'b10;
		i_gpcp_far_model.pulse(1, 1, 3);
		ctr_save(8'h40, 32'h4);
		ctr_save(8'h20, 32'hFFFFFF);
		// Gate pauses and resumes; start value from bank Y, register B
		ctr_start(8'h20, 32'hE5, 0);
		i_gpcp_far_model.pulse(0, 2, 3);
		ctr_save(8'h20, 32'hC30003);
		gate_in <= 2'b01;
		repeat (4) @(posedge pclk);
		i_gpcp_far_model.pulse(0, 3, 3);
		ctr_save(8'h20, 32'hC30006);
		// Gate low again pauses; the next rising gate captures
		gate_in <= 2'b00;
		repeat (4) @(posedge pclk);
		i_gpcp_far_model.pulse(0, 1, 3);
		gate_in <= 2'b01;
		repeat (4) @(posedge pclk);
		xfer(0, 8'h38, 0);
		chk(rdat, 32'hC30006);
		stop_test();
	end
endmodule : gpcp_bench
bind gpcp_top gpcp_top_sva i_gpcp_top_sva (.*);
`default_nettype wire

//--- testbench/gpcp_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module gpcp_far_model (
	input  wire logic       pclk,
	output var  logic [1:0] source_in,
	output var  logic       first_internal_timebase,
	output var  logic       second_internal_timebase
);
	logic [3:0] phase; // Common phase, periods 4 and 6 divide 12
	initial begin
		phase = 4'h0;
		source_in = 2'h0;
		first_internal_timebase = 1'b0;
		second_internal_timebase = 1'b0;
	end
	////////////////////////////////////////////////////////////////
	// Timebases run free, independent of any frame
	always @(posedge pclk) begin
		phase <= (phase == 4'hB) ? 4'h0 : phase + 4'h1;
		first_internal_timebase <= phase[1];
		second_internal_timebase <= (phase % 6) >= 3;
	end
	// Source pulses; a long gap models a slow event stream
	task automatic pulse(input int idx, input int n, input int gap);
		repeat (n) begin
			@(posedge pclk);
			source_in[idx] <= 1'b1;
			repeat (3) @(posedge pclk);
			source_in[idx] <= 1'b0;
			repeat (gap) @(posedge pclk);
		end
	endtask : pulse
endmodule : gpcp_far_model
`default_nettype wire

//--- testbench/gpcp_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module gpcp_top_sva (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic [7:0]  paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        irq,
	input wire logic        counter_zero_out_or_trigger_io_in,
	input wire logic        counter_zero_out_or_trigger_io_oe,
	input wire logic        trigger_io_to_selectors,
	input wire logic        freq_out
);
	// One clock domain, so clocking and reset are stated once
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////
	// Every setup cycle gets its answer in the next cycle
	property p_ready_next;
		psel && !penable |=> pready;
	endproperty
	a_ready_next: assert property (p_ready_next)
		else $error("pready missing after setup");
	// The answer stands for one cycle only
	property p_ready_once;
		pready |=> !pready;
	endproperty
	a_ready_once: assert property (p_ready_once)
		else $error("pready held too long");
	// A refused access reads as zero
	property p_err_zero;
		pslverr |-> pready && prdata == 32'h0;
	endproperty
	a_err_zero: assert property (p_err_zero)
		else $error("refused access returned data");
	// Misaligned addresses are refused
	property p_misalign;
		psel && !penable && paddr[1:0] != 2'h0 |=> pslverr;
	endproperty
	a_misalign: assert property (p_misalign)
		else $error("misaligned access accepted");
	// Outputs quiet at the first edge after release; own reset rule
	property p_rst_out;
		disable iff (1'b0) $rose(presetn) |-> !pready && !irq &&
			!freq_out && !counter_zero_out_or_trigger_io_oe;
	endproperty
	a_rst_out: assert property (p_rst_out)
		else $error("output active after reset");
	// Reading the status register drops the interrupt two edges on
	property p_irq_clear;
		psel && penable && pready && !pwrite && paddr == 8'h08 |->
			##2 !irq;
	endproperty
	a_irq_clear: assert property (p_irq_clear)
		else $error("interrupt survived status read");
	// Fastest timebase edge spacing is four cycles
	property p_freq_gap;
		freq_out |=> !freq_out [*3];
	endproperty
	a_freq_gap: assert property (p_freq_gap)
		else $error("frequency pulses too close");
	// Steady input level reaches the selectors while not driving
	property p_trig_pass;
		!counter_zero_out_or_trigger_io_oe &&
		!$past(counter_zero_out_or_trigger_io_oe) &&
		$stable(counter_zero_out_or_trigger_io_in) &&
		$past(counter_zero_out_or_trigger_io_in, 2) ==
		counter_zero_out_or_trigger_io_in |->
			trigger_io_to_selectors == counter_zero_out_or_trigger_io_in;
	endproperty
	a_trig_pass: assert property (p_trig_pass)
		else $error("pin level not routed to selectors");
	// A driven pin feeds nothing back to the selectors
	property p_trig_block;
		counter_zero_out_or_trigger_io_oe &&
		$past(counter_zero_out_or_trigger_io_oe) |->
			!trigger_io_to_selectors;
	endproperty
	a_trig_block: assert property (p_trig_block)
		else $error("driven pin echoed to selectors");
	// Main scenarios reached
	c_freq: cover property (freq_out);
	c_irq: cover property (irq);
	c_err: cover property (pslverr);
endmodule : gpcp_top_sva
`default_nettype wire
